// File: rtl/pwct_pkg.sv
// package: register map, field positions, reset values and timing for the pulse width count timer
package pwct_pkg;

  // --------------------------------------------------------------------------
  // register byte addresses (apb, one aligned word each)
  // --------------------------------------------------------------------------
  localparam logic [7:0] PWCT_CTRL1_ADDR  = 8'h00;  // control_reg_one
  localparam logic [7:0] PWCT_CTRL2_ADDR  = 8'h04;  // control_reg_two
  localparam logic [7:0] PWCT_RELOAD_ADDR = 8'h08;  // reload_buffer_reg
  localparam logic [7:0] PWCT_FILT_ADDR   = 8'h0c;  // filter_clock_reg

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int PWCT_C1_RUN   = 7;  // counter run bit
  localparam int PWCT_C1_IE    = 5;  // irq_enable_bit
  localparam int PWCT_C1_UF    = 2;  // underflow_flag
  localparam int PWCT_C1_MD    = 1;  // measure_done_flag
  localparam int PWCT_C1_BF    = 0;  // buffer_full_flag
  localparam int PWCT_C2_FUNC  = 7;  // 1 = pulse measurement
  localparam int PWCT_C2_ONE   = 6;  // 1 = one-shot
  localparam int PWCT_C2_TOUT  = 5;  // underflow_output_bit
  localparam int PWCT_C2_CLK   = 2;  // count clock select, 2 bits
  localparam int PWCT_C2_EDGE  = 0;  // edge select, 2 bits

  // --------------------------------------------------------------------------
  // reset values and constants
  // --------------------------------------------------------------------------
  localparam logic [7:0] PWCT_CNT_ALL1   = 8'hff;  // measurement start value
  localparam logic [7:0] PWCT_RELOAD_RST = 8'h00;
  localparam logic [1:0] PWCT_FILT_RST   = 2'h0;
  localparam int         PWCT_MC_DIV     = 4;      // oscillator periods per machine cycle
  localparam int         PWCT_DIV_B      = 4;      // second count clock, machine cycles
  localparam int         PWCT_DIV_C      = 32;     // third count clock, machine cycles
  localparam int         PWCT_FILT_DEPTH = 3;      // integrator length in samples

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWCT_M_HIGH,   // rising to falling
    PWCT_M_CYC_R,  // rising to rising
    PWCT_M_CYC_F,  // falling to falling
    PWCT_M_LOW     // falling to rising
  } pwct_edge_e;

  typedef enum logic [1:0] {PWCT_IDLE, PWCT_ARMED, PWCT_COUNT} pwct_state_e;

  typedef struct packed {
    logic       run;
    logic       ie;
    logic       uf;
    logic       md;
    logic       bf;
    logic       func;
    logic       one;
    logic       tout;
    logic [1:0] clk_sel;
    logic [1:0] edge_sel;
    logic [1:0] filt_sel;
    logic [7:0] reload;
  } pwct_regs_s;

endpackage

// File: rtl/pwct_filter.sv
// noise filter: synchroniser plus sample integrator on a selected timebase tap
`timescale 1ns/10ps
`default_nettype none
module pwct_filter #(
  parameter int DEPTH = pwct_pkg::PWCT_FILT_DEPTH
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       pin_in,    // raw pulse_input_pin
  input  wire logic [2:0] taps,      // timebase sample strobes
  input  wire logic [1:0] sel,       // chosen tap
  output var  logic       filt_out   // cleaned level
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                     s1;     // first sync stage
    logic                     s2;     // second sync stage
    logic [$clog2(DEPTH+1)-1:0] acc;  // integrator
    logic                     lvl;
  } pwct_filt_s;

  pwct_filt_s st_r;
  pwct_filt_s st_nxt;
  logic       strobe;

  // unused tap code 3 simply never samples
  assign strobe = (sel < 2'd3) ? taps[sel] : 1'b0;
  assign filt_out = st_r.lvl;

  // --------------------------------------------------------------------------
  // integrate: level moves only after DEPTH agreeing samples
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    if (strobe) begin
      if (st_r.s2 && st_r.acc != DEPTH[$bits(st_r.acc)-1:0]) begin
        st_nxt.acc = st_r.acc + 1'b1;
      end else if (!st_r.s2 && st_r.acc != '0) begin
        st_nxt.acc = st_r.acc - 1'b1;
      end
      if (st_nxt.acc == DEPTH[$bits(st_r.acc)-1:0]) begin
        st_nxt.lvl = 1'b1;
      end else if (st_nxt.acc == '0) begin
        st_nxt.lvl = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // level never changes without a sample strobe
  filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !strobe) |=> $stable(st_r.lvl)) else $error("filter moved without sample");

endmodule
`default_nettype wire

// File: rtl/pwct_top.sv
// pulse width count timer: apb registers, prescaler, down counter, edge logic, interrupt
//
// Contract
// - function chosen: interval timer or measurement
// - count clocks of 1, 4, 32 machine cycles
// - interval programmable from 1 to 256 clocks
// - reload mode continuous, one-shot mode single
// - reload value zero means 256 counts
// - start from reload, or all ones measuring
// - underflow from one to zero toggles output
// - reload mode reloads counter on underflow
// - measurement end copies counter to buffer
// - start and end edges gate the counter
// - measure high, low, or full period
// - back-to-back measurements without reconfiguration
// - filter samples and integrates pulse input
// - filter clock from three timebase taps
// - underflow raises interrupt when enabled
// - measurement done or unread result interrupts
// - machine cycle is four oscillator periods
// - one-shot underflow clears run bit
// - buffer full set on done, cleared by read
// - writing zero clears flag, one keeps
// - run cleared mid-measure: no transfer, reload ones
`timescale 1ns/10ps
`default_nettype none
module pwct_top #(
  parameter int MC_DIV = pwct_pkg::PWCT_MC_DIV,
  parameter int DIV_B  = pwct_pkg::PWCT_DIV_B,
  parameter int DIV_C  = pwct_pkg::PWCT_DIV_C
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,         // freezes all state while low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulse_input_pin,
  input  wire logic [2:0]  tb_taps,     // timebase filter sample strobes, one pulse each
  output logic             underflow_output_bit,
  output logic             timer_irq_line
);

  // --------------------------------------------------------------------------
  // state record
  // --------------------------------------------------------------------------
  typedef struct packed {
    pwct_pkg::pwct_regs_s  rg;      // software visible
    pwct_pkg::pwct_state_e ms;      // measurement sequencer
    logic [7:0]            cnt;     // down counter
    logic [1:0]            osc;     // oscillator-to-machine-cycle divider
    logic [4:0]            pre;     // machine cycle prescaler
    logic                  flt_d;   // previous filtered level
    logic [31:0]           rdata;   // registered read data
    logic                  rvalid;  // read captured, answer next cycle
  } pwct_state_s;

  pwct_state_s st_r;
  pwct_state_s st_nxt;

  logic       filt_lvl;    // cleaned pulse input
  logic       mc_tick;     // one machine cycle elapsed
  logic       cnt_tick;    // selected count clock edge
  logic       rise;
  logic       fall;
  logic       start_ev;
  logic       end_ev;
  logic       acc;         // apb access phase
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       uf_ev;       // underflow this cycle
  logic       done_ev;     // measurement completed this cycle

  // --------------------------------------------------------------------------
  // noise filter
  // --------------------------------------------------------------------------
  pwct_filter #(
    .DEPTH (pwct_pkg::PWCT_FILT_DEPTH)
  ) u_filt (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .pin_in   (pulse_input_pin),
    .taps     (tb_taps),
    .sel      (st_r.rg.filt_sel),
    .filt_out (filt_lvl)
  );

  // --------------------------------------------------------------------------
  // apb decode: writes answer at once, reads after one wait state;
  // unmapped address answers pslverr
  // --------------------------------------------------------------------------
  assign acc    = psel && penable;
  assign mapped = (paddr == pwct_pkg::PWCT_CTRL1_ADDR) || (paddr == pwct_pkg::PWCT_CTRL2_ADDR) ||
                  (paddr == pwct_pkg::PWCT_RELOAD_ADDR) || (paddr == pwct_pkg::PWCT_FILT_ADDR);
  assign wr      = acc && pwrite && mapped && ce;
  assign rd      = acc && !pwrite && mapped && ce && !st_r.rvalid;
  // read data is registered on the first access cycle and shown on the second,
  // so prdata comes from a flop yet stands at the edge that completes the read
  assign pready  = ce && (pwrite || st_r.rvalid);
  assign pslverr = acc && !mapped;
  assign prdata  = st_r.rdata;

  // --------------------------------------------------------------------------
  // clock chain: pclk is the oscillator, machine cycle = MC_DIV of them
  // --------------------------------------------------------------------------
  assign mc_tick = (st_r.osc == 2'(MC_DIV - 1));
  always_comb begin
    case (st_r.rg.clk_sel)
      2'd0:    cnt_tick = mc_tick;
      2'd1:    cnt_tick = mc_tick && (st_r.pre[1:0] == 2'(DIV_B - 1));
      2'd2:    cnt_tick = mc_tick && (st_r.pre == 5'(DIV_C - 1));
      default: cnt_tick = 1'b0;  // forbidden code stalls the counter
    endcase
  end

  // --------------------------------------------------------------------------
  // edge selection on the filtered level
  // --------------------------------------------------------------------------
  assign rise = filt_lvl && !st_r.flt_d;
  assign fall = !filt_lvl && st_r.flt_d;
  always_comb begin
    case (pwct_pkg::pwct_edge_e'(st_r.rg.edge_sel))
      pwct_pkg::PWCT_M_HIGH: begin
        start_ev = rise;
        end_ev   = fall;
      end
      pwct_pkg::PWCT_M_CYC_R: begin
        start_ev = rise;
        end_ev   = rise;
      end
      pwct_pkg::PWCT_M_CYC_F: begin
        start_ev = fall;
        end_ev   = fall;
      end
      pwct_pkg::PWCT_M_LOW: begin
        start_ev = fall;
        end_ev   = rise;
      end
      default: begin
        start_ev = 1'b0;
        end_ev   = 1'b0;
      end
    endcase
  end

  assign uf_ev   = st_r.rg.run && cnt_tick && (st_r.cnt == 8'h01) &&
                   (!st_r.rg.func || st_r.ms == pwct_pkg::PWCT_COUNT);
  assign done_ev = st_r.rg.run && st_r.rg.func && st_r.ms == pwct_pkg::PWCT_COUNT && end_ev;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.flt_d = filt_lvl;
    // a read answers in its second access cycle; capture and buffer-full clear
    // share the first edge, so a result landing in between is not lost
    st_nxt.rvalid = acc && !pwrite && !st_r.rvalid;
    st_nxt.osc   = mc_tick ? 2'h0 : st_r.osc + 2'h1;
    if (mc_tick) begin
      st_nxt.pre = (st_r.pre == 5'(DIV_C - 1)) ? 5'h0 : st_r.pre + 5'h1;
    end

    // counting
    if (st_r.rg.run) begin
      if (!st_r.rg.func) begin
        if (cnt_tick) begin
          if (st_r.cnt == 8'h01) begin
            st_nxt.cnt = st_r.rg.reload;  // zero reload counts 256
            if (st_r.rg.one) begin
              st_nxt.rg.run = 1'b0;
            end
          end else begin
            st_nxt.cnt = st_r.cnt - 8'h01;
          end
        end
      end else begin
        case (st_r.ms)
          pwct_pkg::PWCT_ARMED: begin
            if (start_ev) begin
              st_nxt.ms  = pwct_pkg::PWCT_COUNT;
              st_nxt.cnt = pwct_pkg::PWCT_CNT_ALL1;
            end
          end
          pwct_pkg::PWCT_COUNT: begin
            if (end_ev) begin
              st_nxt.rg.reload = st_r.cnt;
              // a cycle measurement ends on the next start edge: rearm straight into counting
              st_nxt.ms  = start_ev ? pwct_pkg::PWCT_COUNT : pwct_pkg::PWCT_ARMED;
              st_nxt.cnt = pwct_pkg::PWCT_CNT_ALL1;
            end else if (cnt_tick) begin
              st_nxt.cnt = st_r.cnt - 8'h01;  // wraps 00 to ff and keeps going
            end
          end
          default: st_nxt.ms = pwct_pkg::PWCT_ARMED;
        endcase
      end
    end else begin
      st_nxt.ms = pwct_pkg::PWCT_IDLE;  // stop without transfer
    end

    // register reads; reading the buffer in measurement mode clears buffer full
    if (rd) begin
      st_nxt.rdata = 32'h0;
      case (paddr)
        pwct_pkg::PWCT_CTRL1_ADDR: begin
          st_nxt.rdata[pwct_pkg::PWCT_C1_RUN] = st_r.rg.run;
          st_nxt.rdata[pwct_pkg::PWCT_C1_IE]  = st_r.rg.ie;
          st_nxt.rdata[pwct_pkg::PWCT_C1_UF]  = st_r.rg.uf;
          st_nxt.rdata[pwct_pkg::PWCT_C1_MD]  = st_r.rg.md;
          st_nxt.rdata[pwct_pkg::PWCT_C1_BF]  = st_r.rg.bf;
        end
        pwct_pkg::PWCT_CTRL2_ADDR: begin
          st_nxt.rdata[pwct_pkg::PWCT_C2_FUNC]              = st_r.rg.func;
          st_nxt.rdata[pwct_pkg::PWCT_C2_ONE]               = st_r.rg.one;
          st_nxt.rdata[pwct_pkg::PWCT_C2_TOUT]              = st_r.rg.tout;
          st_nxt.rdata[pwct_pkg::PWCT_C2_CLK +: 2]          = st_r.rg.clk_sel;
          st_nxt.rdata[pwct_pkg::PWCT_C2_EDGE +: 2]         = st_r.rg.edge_sel;
        end
        pwct_pkg::PWCT_RELOAD_ADDR: begin
          st_nxt.rdata[7:0] = st_r.rg.reload;
          if (st_r.rg.func) begin
            st_nxt.rg.bf = 1'b0;
          end
        end
        pwct_pkg::PWCT_FILT_ADDR: st_nxt.rdata[1:0] = st_r.rg.filt_sel;
        default: st_nxt.rdata = 32'h0;
      endcase
    end

    // register writes
    if (wr) begin
      case (paddr)
        pwct_pkg::PWCT_CTRL1_ADDR: begin
          st_nxt.rg.ie = pwdata[pwct_pkg::PWCT_C1_IE];
          if (!pwdata[pwct_pkg::PWCT_C1_UF]) st_nxt.rg.uf = 1'b0;
          if (!pwdata[pwct_pkg::PWCT_C1_MD]) st_nxt.rg.md = 1'b0;
          if (pwdata[pwct_pkg::PWCT_C1_RUN] && !st_r.rg.run) begin
            st_nxt.rg.run = 1'b1;
            st_nxt.cnt    = st_r.rg.func ? pwct_pkg::PWCT_CNT_ALL1 : st_r.rg.reload;
            st_nxt.ms     = pwct_pkg::PWCT_ARMED;
          end else if (!pwdata[pwct_pkg::PWCT_C1_RUN]) begin
            st_nxt.rg.run = 1'b0;
          end
        end
        pwct_pkg::PWCT_CTRL2_ADDR: begin
          st_nxt.rg.func     = pwdata[pwct_pkg::PWCT_C2_FUNC];
          st_nxt.rg.one      = pwdata[pwct_pkg::PWCT_C2_ONE];
          st_nxt.rg.clk_sel  = pwdata[pwct_pkg::PWCT_C2_CLK +: 2];
          st_nxt.rg.edge_sel = pwdata[pwct_pkg::PWCT_C2_EDGE +: 2];
        end
        pwct_pkg::PWCT_RELOAD_ADDR: begin
          // measurement mode makes the buffer read-only
          if (!st_r.rg.func) st_nxt.rg.reload = pwdata[7:0];
        end
        pwct_pkg::PWCT_FILT_ADDR: st_nxt.rg.filt_sel = pwdata[1:0];
        default: ;
      endcase
    end

    // hardware events set last so they win over a same-cycle clear
    if (uf_ev) begin
      st_nxt.rg.uf   = 1'b1;
      st_nxt.rg.tout = ~st_r.rg.tout;
    end
    if (done_ev) begin
      st_nxt.rg.md = 1'b1;
      st_nxt.rg.bf = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.ms        <= pwct_pkg::PWCT_IDLE;
      st_r.rg.reload <= pwct_pkg::PWCT_RELOAD_RST;
      st_r.rg.filt_sel <= pwct_pkg::PWCT_FILT_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign underflow_output_bit = st_r.rg.tout;
  assign timer_irq_line = st_r.rg.ie && (st_r.rg.uf || st_r.rg.md || st_r.rg.bf);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  irq_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_r.rg.ie && (uf_ev || done_ev) && !wr) |=> timer_irq_line)
    else $error("irq missing after timer event");
  uf_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && uf_ev) |=> (st_r.rg.uf && underflow_output_bit != $past(underflow_output_bit)))
    else $error("underflow did not toggle output");
  reload_uf_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && uf_ev && !st_r.rg.func && !wr) |=> st_r.cnt == $past(st_r.rg.reload))
    else $error("counter not reloaded");
  oneshot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && uf_ev && !st_r.rg.func && st_r.rg.one && !wr) |=> !st_r.rg.run)
    else $error("one-shot kept running");
  meas_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && done_ev) |=> (st_r.rg.reload == $past(st_r.cnt) && st_r.rg.bf && st_r.rg.md))
    else $error("measurement not captured");
  bf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == pwct_pkg::PWCT_RELOAD_ADDR && st_r.rg.func && !done_ev) |=> !st_r.rg.bf)
    else $error("buffer full not cleared by read");
  start_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_r.rg.run && st_r.rg.func && st_r.ms == pwct_pkg::PWCT_ARMED && start_ev && !wr)
    |=> (st_r.cnt == 8'hff && st_r.ms == pwct_pkg::PWCT_COUNT))
    else $error("measurement did not start from ones");
  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_r.rg.run && !wr) |=> $stable(st_r.rg.reload) && $stable(st_r.cnt))
    else $error("stopped counter changed");
  w1_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == pwct_pkg::PWCT_CTRL1_ADDR && pwdata[pwct_pkg::PWCT_C1_UF] && st_r.rg.uf) |=> st_r.rg.uf)
    else $error("write one cleared flag");
  tout_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !uf_ev) |=> $stable(underflow_output_bit))
    else $error("output toggled without underflow");
  md_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_r.rg.md && !done_ev) |=> !st_r.rg.md)
    else $error("done flag set without measurement");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_r.rg.run && !st_r.rg.func && cnt_tick && st_r.cnt != 8'h01 && !wr)
    |=> st_r.cnt == $past(st_r.cnt) - 8'h01) else $error("interval counter did not step");

endmodule
`default_nettype wire

// File: dv/pwct_pulse_src.sv
// pulse source model: drives the measured input with fixed high and low widths
`timescale 1ns/10ps
`default_nettype none
module pwct_pulse_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        en,       // high while pulses are wanted
  input  wire logic [15:0] hi_len,   // high width in pclk cycles
  input  wire logic [15:0] lo_len,   // low width in pclk cycles
  output var  logic        pin       // level seen by the timer input
);
  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;  // cycles spent in the present level

  // idles low so that every burst starts with a clean rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin   <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (!en) begin
      pin   <= 1'b0;  // pin held low while pulses are off
      cnt_r <= 16'h0000;
    end else if (cnt_r + 16'h0001 >= (pin ? hi_len : lo_len)) begin
      pin   <= ~pin;  // level change at the end of each width
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// testbench: apb-driven checks of the pulse width count timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pin, tout, irq, src_en, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  taps;    // filter strobes at three rates
  logic [3:0]  tb_cnt;  // divider behind the strobes
  int          errors, n_compared, n, n_uf;
  logic [15:0] hi_w;    // high width of the source pulse, pclk cycles
  logic [7:0]  rl_t[4]  = '{8'h03, 8'h01, 8'h00, 8'h02};  // reload values
  logic [1:0]  cs_t[4]  = '{2'h0, 2'h1, 2'h0, 2'h2};      // count clock picks
  int          per_t[4] = '{12, 16, 1024, 256};          // 4 * clock factor * count
  int          wid_t[4] = '{10, 30, 30, 20};             // machine cycles per mode

  pwct_top DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_input_pin(pin), .tb_taps(taps), .underflow_output_bit(tout),
    .timer_irq_line(irq));
  pwct_pulse_src SRC (.pclk(pclk), .presetn(presetn), .en(src_en), .hi_len(hi_w),
    .lo_len(16'h0050), .pin(pin));

  // ----------------------------------------------------------------
  // clock, timebase strobes and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tb_cnt <= tb_cnt + 4'h1;
    taps   <= {tb_cnt[1:0] == 2'h0, tb_cnt[0] == 1'b0, 1'b1};
  end
  // whole run is a few thousand cycles; this leaves wide margin
  initial begin
    #300us;
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  // entered just after a rising edge; waits for pready, takes data at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t apb access never answered", $time);
    end
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // counts cycles until the timer output changes level
  task automatic wait_tog(output int c);
    logic old;
    old = tout;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (tout === old && c < 5000);
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, src_en, taps, tb_cnt} = '0;
    errors = 0;
    n_compared = 0;
    n_uf = 0;
    hi_w = 16'h0028;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, rd);
      chk(rd, 32'h0, "reset value");
    end
    apb(1'b0, 8'h10, 32'h0, rd);
    chk({31'h0, slv}, 32'h1, "unmapped error");
    // reload mode periods over count clocks and reload values, zero meaning 256
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 32'h0, rd);
      apb(1'b1, 8'h04, {28'h0, cs_t[i], 2'h0}, rd);
      apb(1'b1, 8'h08, {24'h0, rl_t[i]}, rd);
      apb(1'b1, 8'h00, 32'h80, rd);
      wait_tog(n);
      wait_tog(n);
      chk(32'(n), 32'(per_t[i]), "interval length");
    end
    // one-shot stops itself and leaves the underflow flag
    apb(1'b1, 8'h00, 32'h0, rd);
    apb(1'b1, 8'h04, 32'h40, rd);
    apb(1'b1, 8'h00, 32'h80, rd);
    wait_tog(n);
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h04, "one-shot status");
    apb(1'b1, 8'h00, 32'h24, rd);
    chk({31'h0, irq}, 32'h1, "irq on underflow");
    apb(1'b1, 8'h00, 32'h20, rd);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    // measurement in all four edge modes
    for (int m = 0; m < 4; m++) begin
      src_en <= 1'b0;
      apb(1'b1, 8'h00, 32'h0, rd);
      apb(1'b1, 8'h04, 32'h80 | 32'(m), rd);
      apb(1'b1, 8'h00, 32'ha0, rd);
      src_en <= 1'b1;
      rd = 32'h0;
      for (n = 0; n < 150 && rd[1] !== 1'b1; n++)
        apb(1'b0, 8'h00, 32'h0, rd);
      chk(rd, 32'ha3, "done and full");
      chk({31'h0, irq}, 32'h1, "irq on result");
      apb(1'b0, 8'h08, 32'h0, rd);
      n = 255 - wid_t[m] - int'(rd);
      chk({31'h0, n >= -2 && n <= 2}, 32'h1, "measured width");
      apb(1'b0, 8'h00, 32'h0, rd);
      chk({31'h0, rd[0]}, 32'h0, "full flag after read");
    end
    // long high pulse on the slow filter tap: software adds 256 counts per underflow seen
    src_en <= 1'b0;
    hi_w   <= 16'h04b0;
    apb(1'b1, 8'h00, 32'h0, rd);
    apb(1'b1, 8'h0c, 32'h2, rd);
    apb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h2, "filter tap select");
    apb(1'b1, 8'h04, 32'h80, rd);
    apb(1'b1, 8'h00, 32'h80, rd);
    src_en <= 1'b1;
    rd = 32'h0;
    for (n = 0; n < 600 && rd[1] !== 1'b1; n++) begin
      apb(1'b0, 8'h00, 32'h0, rd);
      if (rd[2] === 1'b1) begin
        n_uf++;
        apb(1'b1, 8'h00, 32'h82, rd);
      end
    end
    apb(1'b0, 8'h08, 32'h0, rd);
    n = 256 * n_uf + 255 - int'(rd) - 300;
    chk({31'h0, n_uf == 1 && n >= -2 && n <= 2}, 32'h1, "long pulse width");
    report_and_stop();
  end
endmodule
`default_nettype wire
